// File: pcl_host.sv
`timescale 1ns/10ps
module pcl_host #(
  parameter int P_CF2CK_NS = 2000
) (
  // Host-driven pins
  output logic o_reconfig_b,
  output logic o_cfg_clock,
  output logic [15:0] o_cfg_data,
  output logic o_user_init_clock,
  // Device feedback
  input wire logic i_status,
  input wire logic i_load_complete
);
  initial begin
    o_reconfig_b = 1'b1;
    o_cfg_clock = 1'b0;
    o_cfg_data = 16'h0000;
    o_user_init_clock = 1'b0;
  end

  // Odd half period walks the init clock across the system clock grid; every fifth toggle lands on an edge
  always begin
    #83 o_user_init_clock = ~o_user_init_clock;
  end

  task automatic reconfig(input int low_ns);
    #3;
    o_reconfig_b = 1'b0;
    #(low_ns);
    o_reconfig_b = 1'b1;
  endtask : reconfig

  // gap after request, then after status release
  task automatic wait_ready();
    #(P_CF2CK_NS);
    wait (i_status === 1'b1);
    #2003;
  endtask : wait_ready

  // 160 ns period, both phases far above the minimum
  task automatic tick();
    #80 o_cfg_clock = 1'b1;
    #80 o_cfg_clock = 1'b0;
  endtask : tick

  // word held r periods, the last word too
  // pause with clock low, next word set before the edge
  task automatic send(input int n, input int r, input logic [15:0] base,
                      input int pause_at);
    for (int i = 0; i < n; i++) begin
      if (i == pause_at) begin
        o_cfg_data = ~o_cfg_data;
        #2000;
      end
      o_cfg_data = base + 16'(i);
      repeat (r) tick();
    end
    // Released bus must not keep showing the last word
    o_cfg_data = ~o_cfg_data;
  endtask : send

  // two falling edges, clock then parked low
  task automatic finish();
    wait (i_load_complete === 1'b1);
    #3;
    repeat (2) tick();
  endtask : finish
endmodule : pcl_host

// File: pcl_loader.sv
`timescale 1ns/10ps
module pcl_loader #(
  parameter int P_POR_CYC = pcl_pkg::PCL_STATUS_MIN_CYC,
  parameter int P_STATUS_MIN_CYC = pcl_pkg::PCL_STATUS_MIN_CYC,
  parameter int P_STATUS_MAX_CYC = pcl_pkg::PCL_STATUS_MAX_CYC,
  parameter int P_UM_CYC = pcl_pkg::PCL_UM_MIN_CYC,
  parameter int P_TINIT = pcl_pkg::PCL_TINIT
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Configuration pins
  input wire logic i_reconfig_b,
  input wire logic i_cfg_clock,
  input wire logic [15:0] i_cfg_data,
  input wire logic i_status_in,
  input wire logic i_user_init_clock,
  output logic o_status_out,
  output logic o_status_oe,
  output logic o_load_complete,
  output logic o_init_done,
  output logic o_user_mode,
  // Received words
  output logic [15:0] o_word,
  output logic o_word_vld,
  // Register port
  input wire logic [3:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata
);
  localparam int CW = 18;
  localparam int UW = 15;

  pcl_pkg::pcl_pins_t pins_a;
  pcl_pkg::pcl_pins_t pins_s;
  pcl_pkg::pcl_state_t state_q;
  pcl_pkg::pcl_state_t state_d;
  pcl_pkg::pcl_ctrl_t ctrl_q;
  logic [31:0] len_q;
  logic [31:0] wcnt_q;
  logic [CW-1:0] cnt_q;
  logic [UW-1:0] ucnt_q;
  logic gate_ok_q;
  logic [1:0] phase_q;
  logic [1:0] rm1;
  logic [1:0] falls_q;
  logic cclk_q;
  logic ucl_q;
  logic cclk_rise;
  logic cclk_fall;
  logic ucl_rise;
  logic take_word;
  logic last_word;
  logic init_end;

  // ------------------------------------------------------------
  // Pin synchronisers and edge finding
  // ------------------------------------------------------------
  assign pins_a = '{data: i_cfg_data, user_clk: i_user_init_clock,
                    status_line: i_status_in, cfg_clock: i_cfg_clock,
                    reconfig_b: i_reconfig_b};

  pcl_sync2 #(.WIDTH($bits(pcl_pkg::pcl_pins_t))) u_sync (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_async(pins_a),
    .o_sync(pins_s)
  );

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cclk_q <= 1'b0;
      ucl_q <= 1'b0;
    end else begin
      cclk_q <= pins_s.cfg_clock;
      ucl_q <= pins_s.user_clk;
    end
  end

  assign cclk_rise = pins_s.cfg_clock & ~cclk_q;
  assign cclk_fall = ~pins_s.cfg_clock & cclk_q;
  assign ucl_rise = pins_s.user_clk & ~ucl_q;

  // ------------------------------------------------------------
  // Ratio and word sampling
  // ------------------------------------------------------------
  // ratio from width, compression and encryption
  always_comb begin
    if (ctrl_q.wide16) begin
      rm1 = ctrl_q.compress ? pcl_pkg::PCL_RM1_X4 :
            ctrl_q.encrypt ? pcl_pkg::PCL_RM1_X2 : pcl_pkg::PCL_RM1_X1;
    end else begin
      rm1 = ctrl_q.compress ? pcl_pkg::PCL_RM1_X2 : pcl_pkg::PCL_RM1_X1;
    end
  end

  // Clock edges while the status wire is held low elsewhere are ignored
  // sample on phase zero
  assign take_word = (state_q == pcl_pkg::PCL_ST_LOAD) && cclk_rise &&
                     pins_s.status_line && (phase_q == 2'h0);
  assign last_word = take_word && (wcnt_q + 32'h1 >= len_q);

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      phase_q <= 2'h0;
    end else if (state_q != pcl_pkg::PCL_ST_LOAD) begin
      phase_q <= 2'h0;
    end else if (cclk_rise && pins_s.status_line) begin
      phase_q <= (phase_q == rm1) ? 2'h0 : phase_q + 2'h1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_word <= 16'h0000;
      o_word_vld <= 1'b0;
    end else begin
      o_word_vld <= take_word;
      if (take_word) begin
        o_word <= ctrl_q.wide16 ? pins_s.data : {8'h00, pins_s.data[7:0]};
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wcnt_q <= 32'h0;
    end else if (state_q == pcl_pkg::PCL_ST_RST) begin
      wcnt_q <= 32'h0;
    end else if (take_word) begin
      wcnt_q <= wcnt_q + 32'h1;
    end
  end

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  assign init_end = ctrl_q.use_user_clk ?
    (gate_ok_q && ucl_rise && ucnt_q == UW'(P_TINIT - 1)) :
    (cnt_q == CW'(P_UM_CYC - 1));

  always_comb begin
    state_d = state_q;
    case (state_q)
      pcl_pkg::PCL_ST_POR: begin
        if (cnt_q == CW'(P_POR_CYC - 1)) begin
          state_d = pins_s.reconfig_b ? pcl_pkg::PCL_ST_LOAD :
                                        pcl_pkg::PCL_ST_RST;
        end
      end
      pcl_pkg::PCL_ST_RST: begin
        if (pins_s.reconfig_b && cnt_q >= CW'(P_STATUS_MIN_CYC - 1)) begin
          state_d = pcl_pkg::PCL_ST_LOAD;
        end
      end
      pcl_pkg::PCL_ST_LOAD: begin
        if (last_word) begin
          state_d = pcl_pkg::PCL_ST_DONE;
        end
      end
      pcl_pkg::PCL_ST_DONE: begin
        if (cclk_fall && falls_q == pcl_pkg::PCL_DONE_FALLS - 2'h1) begin
          state_d = pcl_pkg::PCL_ST_INIT;
        end
      end
      pcl_pkg::PCL_ST_INIT: begin
        if (init_end) begin
          state_d = pcl_pkg::PCL_ST_USER;
        end
      end
      pcl_pkg::PCL_ST_USER: begin
        state_d = pcl_pkg::PCL_ST_USER;
      end
      default: begin
        state_d = pcl_pkg::PCL_ST_POR;
      end
    endcase
    if (!pins_s.reconfig_b && state_q != pcl_pkg::PCL_ST_POR) begin
      state_d = pcl_pkg::PCL_ST_RST;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= pcl_pkg::PCL_ST_POR;
    end else begin
      state_q <= state_d;
    end
  end

  // Shared counter restarts on every state change; it saturates
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= '0;
    end else if (state_d != state_q) begin
      cnt_q <= '0;
    end else if (cnt_q != '1) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      falls_q <= 2'h0;
    end else if (state_q != pcl_pkg::PCL_ST_DONE) begin
      falls_q <= 2'h0;
    end else if (cclk_fall) begin
      falls_q <= falls_q + 2'h1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      gate_ok_q <= 1'b0;
    end else if (state_q != pcl_pkg::PCL_ST_INIT) begin
      gate_ok_q <= 1'b0;
    end else if (cnt_q == CW'(pcl_pkg::PCL_CU_CYC - 1)) begin
      gate_ok_q <= 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ucnt_q <= '0;
    end else if (!gate_ok_q) begin
      ucnt_q <= '0;
    end else if (ucl_rise) begin
      ucnt_q <= ucnt_q + UW'(1);
    end
  end

  // ------------------------------------------------------------
  // Pin outputs
  // ------------------------------------------------------------
  // status low fast
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_status_oe <= 1'b1;
      o_status_out <= 1'b0;
    end else begin
      o_status_oe <= (state_d == pcl_pkg::PCL_ST_POR) ||
                     (state_d == pcl_pkg::PCL_ST_RST);
      o_status_out <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_load_complete <= 1'b0;
      o_user_mode <= 1'b0;
    end else begin
      o_load_complete <= (state_d == pcl_pkg::PCL_ST_DONE) ||
                         (state_d == pcl_pkg::PCL_ST_INIT) ||
                         (state_d == pcl_pkg::PCL_ST_USER);
      o_user_mode <= state_d == pcl_pkg::PCL_ST_USER;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_init_done <= 1'b1;
    end else begin
      o_init_done <= !(ctrl_q.init_done_en &&
                       (state_d == pcl_pkg::PCL_ST_DONE ||
                        state_d == pcl_pkg::PCL_ST_INIT));
    end
  end

  // ------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------
  // Changing options mid-load corrupts the ratio; software must not
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_q <= pcl_pkg::PCL_CTRL_RST;
      len_q <= pcl_pkg::PCL_LEN_RST;
    end else if (i_reg_wr) begin
      if (i_reg_addr == pcl_pkg::PCL_OFS_CTRL) begin
        ctrl_q <= i_reg_wdata[pcl_pkg::PCL_CTRL_W-1:0];
      end
      if (i_reg_addr == pcl_pkg::PCL_OFS_LEN) begin
        len_q <= i_reg_wdata;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 32'h0;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        pcl_pkg::PCL_OFS_CTRL: o_reg_rdata <= {27'h0, ctrl_q};
        pcl_pkg::PCL_OFS_LEN: o_reg_rdata <= len_q;
        pcl_pkg::PCL_OFS_STAT: o_reg_rdata <= {26'h0, phase_q, 1'b0, state_q};
        pcl_pkg::PCL_OFS_WCNT: o_reg_rdata <= wcnt_q;
        default: o_reg_rdata <= 32'h0;
      endcase
    end else begin
      o_reg_rdata <= 32'h0;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  localparam int CF2ST_CYC = pcl_pkg::PCL_CF2ST_CYC;
  logic [CW-1:0] hi_cnt_q;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hi_cnt_q <= '0;
    end else if (!pins_s.reconfig_b || !o_status_oe) begin
      hi_cnt_q <= '0;
    end else if (hi_cnt_q != '1) begin
      hi_cnt_q <= hi_cnt_q + CW'(1);
    end
  end

  a_user_lines_high: assert property (
    o_user_mode |-> !o_status_oe && o_load_complete
  ) else $error("user mode without released lines");
  a_done_drop_fast: assert property (
    $fell(pins_s.reconfig_b) |-> ##[1:CF2ST_CYC] !o_load_complete
  ) else $error("load-complete not low in time");
  a_status_drop_fast: assert property (
    $fell(pins_s.reconfig_b) |-> ##[1:CF2ST_CYC] o_status_oe
  ) else $error("status not low in time");
  a_por_status_hold: assert property (
    state_q == pcl_pkg::PCL_ST_POR |-> o_status_oe
  ) else $error("status released during power-on");
  a_load_keeps_low: assert property (
    state_q == pcl_pkg::PCL_ST_LOAD && !last_word |=> !o_load_complete
  ) else $error("load-complete high during loading");
  a_status_min_low: assert property (
    $fell(o_status_oe) && $past(state_q) == pcl_pkg::PCL_ST_RST
      |-> $past(cnt_q, 2) >= CW'(P_STATUS_MIN_CYC - 2)
  ) else $error("status low pulse too short");
  a_status_max_wait: assert property (
    hi_cnt_q <= CW'(P_STATUS_MAX_CYC)
  ) else $error("status held low too long");
  a_done_after_image: assert property (
    $rose(o_load_complete) |-> wcnt_q >= len_q
  ) else $error("load-complete before whole image");
  a_initdone_low: assert property (
    ctrl_q.init_done_en && o_load_complete && !o_user_mode
      |-> !o_init_done
  ) else $error("init-done high before user mode");
  a_osc_init_time: assert property (
    $rose(o_user_mode) && !ctrl_q.use_user_clk
      |-> $past(cnt_q) == CW'(P_UM_CYC - 1)
  ) else $error("oscillator init length wrong");
  a_user_clk_gate: assert property (
    state_q == pcl_pkg::PCL_ST_INIT && cnt_q < CW'(pcl_pkg::PCL_CU_CYC)
      |-> ucnt_q == '0
  ) else $error("user clock counted too early");
  a_user_init_count: assert property (
    $rose(o_user_mode) && ctrl_q.use_user_clk
      |-> $past(ucnt_q, 2) == UW'(P_TINIT - 1)
  ) else $error("user clock init count wrong");
  a_word_phase: assert property (
    o_word_vld |-> $past(phase_q) == 2'h0 && $past(cclk_rise)
  ) else $error("word taken off phase zero");

  c_reload: cover property ($fell(pins_s.reconfig_b) ##[1:20] o_status_oe);
  c_image_done: cover property ($rose(o_load_complete));
  c_user_entry: cover property ($rose(o_user_mode));
  c_ratio_four: cover property (o_word_vld && rm1 == pcl_pkg::PCL_RM1_X4);
endmodule : pcl_loader

// File: pcl_pkg.sv
package pcl_pkg;
  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [3:0] PCL_OFS_CTRL = 4'h0;
  localparam logic [3:0] PCL_OFS_LEN = 4'h4;
  localparam logic [3:0] PCL_OFS_STAT = 4'h8;
  localparam logic [3:0] PCL_OFS_WCNT = 4'hC;
  localparam int PCL_CTRL_W = 5;
  localparam logic [4:0] PCL_CTRL_RST = 5'h00;
  localparam logic [31:0] PCL_LEN_RST = 32'h0000_0100;

  // ------------------------------------------------------------
  // Timing figures and derived cycle counts
  // ------------------------------------------------------------
  localparam int PCL_CLK_PS = 10000;
  localparam int PCL_CF2ST_NS = 600;
  localparam int PCL_CF2ST_CYC = (PCL_CF2ST_NS * 1000) / PCL_CLK_PS;
  localparam int PCL_STATUS_MIN_US = 268;
  localparam int PCL_STATUS_MAX_US = 1506;
  localparam int PCL_UM_MIN_US = 175;
  localparam int PCL_UM_MAX_US = 437;
  localparam int PCL_STATUS_MIN_CYC =
    (PCL_STATUS_MIN_US * 1000000 + PCL_CLK_PS - 1) / PCL_CLK_PS;
  localparam int PCL_STATUS_MAX_CYC =
    (PCL_STATUS_MAX_US * 1000000) / PCL_CLK_PS;
  localparam int PCL_UM_MIN_CYC =
    (PCL_UM_MIN_US * 1000000 + PCL_CLK_PS - 1) / PCL_CLK_PS;
  localparam int PCL_UM_MAX_CYC = (PCL_UM_MAX_US * 1000000) / PCL_CLK_PS;
  localparam int PCL_CFG_CLOCK_MIN_PS = 8000;
  localparam int PCL_CU_PERIODS = 4;
  localparam int PCL_CU_CYC =
    (PCL_CU_PERIODS * PCL_CFG_CLOCK_MIN_PS + PCL_CLK_PS - 1) / PCL_CLK_PS;
  localparam int PCL_TINIT = 17408;
  localparam logic [1:0] PCL_DONE_FALLS = 2'h2;

  // ------------------------------------------------------------
  // Clock-to-data ratio minus one
  // ------------------------------------------------------------
  localparam logic [1:0] PCL_RM1_X1 = 2'h0;
  localparam logic [1:0] PCL_RM1_X2 = 2'h1;
  localparam logic [1:0] PCL_RM1_X4 = 2'h3;

  typedef enum logic [2:0] {
    PCL_ST_POR = 3'b000,
    PCL_ST_RST = 3'b001,
    PCL_ST_LOAD = 3'b010,
    PCL_ST_DONE = 3'b011,
    PCL_ST_INIT = 3'b100,
    PCL_ST_USER = 3'b101
  } pcl_state_t;

  typedef struct packed {
    logic init_done_en;
    logic use_user_clk;
    logic encrypt;
    logic compress;
    logic wide16;
  } pcl_ctrl_t;

  typedef struct packed {
    logic [15:0] data;
    logic user_clk;
    logic status_line;
    logic cfg_clock;
    logic reconfig_b;
  } pcl_pins_t;
endpackage : pcl_pkg

// File: pcl_sync2.sv
`timescale 1ns/10ps
module pcl_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Data
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;

  // Second stage is the only reader of the first
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule : pcl_sync2

// File: testbench.sv
`timescale 1ns/10ps
module testbench;
  localparam int P_POR = 40;
  localparam int P_SMIN = 40;
  localparam int P_SMAX = 200;
  localparam int P_UM = 50;
  localparam int P_TI = 20;
  localparam int UC_MIN = P_TI * 166 / 10;
  logic mclk, rst_b, reconfig_b, cfg_clock, user_clk, status_w;
  logic status_out, status_oe, load_complete, init_done, user_mode;
  logic [15:0] cfg_data, word;
  logic word_vld, reg_wr, reg_rd;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  int failures = 0;
  int num_checks = 0;
  int exp_n = 0;
  int t;
  logic [15:0] got [$];
  logic [4:0] c_tab [5] = '{5'h12, 5'h05, 5'h07, 5'h04, 5'h1B};
  int r_tab [5] = '{2, 2, 4, 1, 4};
  int n_tab [5] = '{3, 4, 2, 3, 2};
  int lo_tab [5] = '{200, 1000, 200, 200, 200};
  int pz_tab [5] = '{1, -1, -1, 2, -1};

  // Open-drain status wire with pull-up
  assign status_w = status_oe ? status_out : 1'b1;

  pcl_loader #(.P_POR_CYC(P_POR), .P_STATUS_MIN_CYC(P_SMIN),
    .P_STATUS_MAX_CYC(P_SMAX), .P_UM_CYC(P_UM), .P_TINIT(P_TI)) DUT (
    .i_mclk(mclk), .i_rst_b(rst_b), .i_reconfig_b(reconfig_b),
    .i_cfg_clock(cfg_clock), .i_cfg_data(cfg_data), .i_status_in(status_w),
    .i_user_init_clock(user_clk), .o_status_out(status_out),
    .o_status_oe(status_oe), .o_load_complete(load_complete),
    .o_init_done(init_done), .o_user_mode(user_mode), .o_word(word),
    .o_word_vld(word_vld), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata));

  pcl_host #(.P_CF2CK_NS(P_SMAX * 10)) host (
    .o_reconfig_b(reconfig_b), .o_cfg_clock(cfg_clock),
    .o_cfg_data(cfg_data), .o_user_init_clock(user_clk),
    .i_status(status_w), .i_load_complete(load_complete));

  always begin
    #5 mclk = ~mclk;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic reg_wrt(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : reg_wrt

  task automatic reg_red(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_red

  function automatic logic sig(input int k);
    case (k)
      0: return status_oe;
      1: return load_complete;
      default: return user_mode;
    endcase
  endfunction : sig

  // Bounded wait; t counts settled samples
  task automatic wait_lvl(input int k, input logic v, input int lim,
                          output int t);
    t = 0;
    while (sig(k) !== v && t < lim) begin
      @(posedge mclk);
      #1;
      t++;
    end
  endtask : wait_lvl

  always begin
    @(posedge mclk);
    #1;
    if (word_vld === 1'b1) begin
      got.push_back(word);
      check(32'(load_complete), 32'(got.size() == exp_n));
    end
  end

  // ------------------------------------------------------------
  // One full load in the given mode
  // ------------------------------------------------------------
  task automatic run_load(input int m);
    logic [4:0] c;
    logic [15:0] base;
    logic [15:0] exp;
    int w;
    c = c_tab[m];
    base = {c, 11'h4D3};
    got.delete();
    exp_n = n_tab[m];
    reg_wrt(pcl_pkg::PCL_OFS_CTRL, {27'h0, c});
    reg_wrt(pcl_pkg::PCL_OFS_LEN, 32'(n_tab[m]));
    fork
      begin
        host.reconfig(lo_tab[m]);
        host.wait_ready();
        host.send(n_tab[m], r_tab[m], base, pz_tab[m]);
        host.finish();
      end
    join_none
    wait (reconfig_b === 1'b0);
    wait_lvl(1, 1'b0, 60, w);
    check({31'h0, w < 60}, 32'h1); // prompt
    wait_lvl(0, 1'b1, 60, w);
    check({31'h0, w < 60}, 32'h1); // prompt
    check({31'h0, status_w}, 32'h0); // wire pulled low
    wait_lvl(0, 1'b0, 2000, w);
    check({31'h0, w >= P_SMIN - 6}, 32'h1); // minimum pulse
    check({31'h0, w <= lo_tab[m] / 10 + P_SMAX}, 32'h1); // release
    wait_lvl(1, 1'b1, 6000, w);
    check({31'h0, w < 6000}, 32'h1); // image complete
    // The last word lands in this same sample; let the collector run first
    #1;
    check(32'(got.size()), 32'(n_tab[m])); // one per r
    for (int i = 0; i < n_tab[m]; i++) begin
      exp = c[0] ? base + 16'(i) : {8'h00, 8'(base + 16'(i))};
      check({16'h0, got[i]}, {16'h0, exp}); // word order
    end
    check({31'h0, init_done}, {31'h0, ~c[4]}); // held low
    wait_lvl(2, 1'b1, 800, w);
    if (c[3]) begin
      check(32'(w >= UC_MIN-16 && w <= UC_MIN+120), 32'h1);
    end else begin
      check({31'h0, w >= P_UM && w <= P_UM + 100}, 32'h1); // osc
    end
    check({29'h0, status_oe, load_complete, init_done}, 32'h3);
    reg_red(pcl_pkg::PCL_OFS_STAT, rd);
    check(rd & 32'h7, 32'h5); // user state
    reg_red(pcl_pkg::PCL_OFS_WCNT, rd);
    check(rd, 32'(n_tab[m])); // words counted
    $display("test mode %h done", c);
  endtask : run_load

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (6) @(posedge mclk);
    check({30'h0, status_oe, load_complete}, 32'h2); // reset
    rst_b <= 1'b1;
    wait_lvl(0, 1'b0, 200, t);
    check({31'h0, t >= P_POR - 2 && t <= P_POR + 10}, 32'h1); // delay
    reg_red(pcl_pkg::PCL_OFS_CTRL, rd);
    check(rd, {27'h0, pcl_pkg::PCL_CTRL_RST}); // reset value
    reg_red(pcl_pkg::PCL_OFS_LEN, rd);
    check(rd, pcl_pkg::PCL_LEN_RST); // reset value
    reg_wrt(4'h6, 32'hFFFF_FFFF);
    reg_red(4'h6, rd);
    check(rd, 32'h0); // unmapped reads zero
    $display("test reset done");
    for (int m = 0; m < 5; m++) begin
      run_load(m);
    end
    summarize();
  end

  // Whole run is near 40 us; over twelve times that means a hang
  initial begin
    #500000;
    failures++;
    summarize();
  end
endmodule : testbench
